// file: cac_pkg.sv
// shared constants, types and helpers for the register-address access checker
package cac_pkg;

  // address field and instruction field positions
  localparam int ADDR_W     = 12;
  localparam int ACC_HI     = 11;
  localparam int ACC_LO     = 10;
  localparam int LVL_HI     = 9;
  localparam int LVL_LO     = 8;
  localparam int INSTR_W    = 32;
  localparam int CSR_HI     = 31;
  localparam int CSR_LO     = 20;
  localparam int RS1_HI     = 19;
  localparam int RS1_LO     = 15;
  localparam int F3_HI      = 14;
  localparam int F3_LO      = 12;
  localparam int RD_HI      = 11;
  localparam int RD_LO      = 7;
  localparam int OPC_HI     = 6;

  localparam logic [6:0] OPC_SYSTEM = 7'h73;
  localparam logic [1:0] ACC_RO     = 2'h3;
  localparam logic [1:0] F3_SWAP    = 2'h1;
  localparam logic [1:0] F3_SET     = 2'h2;
  localparam logic [1:0] F3_CLR     = 2'h3;

  typedef enum logic [1:0] {
    PRIV_USER  = 2'h0,
    PRIV_SUPER = 2'h1,
    PRIV_HYP   = 2'h2,
    PRIV_MACH  = 2'h3
  } cac_priv_t;

  // address ranges, inclusive
  localparam logic [11:0] DBG_M_LO  = 12'h7A0;
  localparam logic [11:0] DBG_M_HI  = 12'h7AF;
  localparam logic [11:0] DBG_D_LO  = 12'h7B0;
  localparam logic [11:0] DBG_D_HI  = 12'h7BF;
  localparam logic [11:0] CNT_LO    = 12'hC00;
  localparam logic [11:0] CNT_HI    = 12'hC1F;
  localparam logic [11:0] CNTH_LO   = 12'hC80;
  localparam logic [11:0] CNTH_HI   = 12'hC9F;
  localparam logic [11:0] SHD_LO    = 12'hB00;
  localparam logic [11:0] SHD_HI    = 12'hB1F;
  localparam logic [11:0] SHDH_LO   = 12'hB80;
  localparam logic [11:0] SHDH_HI   = 12'hB9F;
  localparam logic [3:0]  UCUST_TOP = 4'h8;
  localparam logic [3:0]  USTD_TOP  = 4'h4;
  localparam logic [1:0]  CUST_SUB  = 2'h3;

  // software register map
  localparam int REG_AW = 4;
  localparam logic [3:0] REG_STATUS    = 4'h0;
  localparam logic [3:0] REG_MASK      = 4'h4;
  localparam logic [3:0] REG_INTERCEPT = 4'h8;
  localparam logic [3:0] REG_REJECTS   = 4'hC;

  // event bits of status and mask
  localparam int NUM_EV       = 3;
  localparam int EV_ILLEGAL   = 0;
  localparam int EV_DEBUG     = 1;
  localparam int EV_INTERCEPT = 2;

  // intercept control bits
  localparam int IC_U_CNT  = 0;
  localparam int IC_S_CNT  = 1;
  localparam int IC_CUST   = 2;
  localparam int NUM_IC    = 3;

  localparam logic [NUM_EV-1:0] STATUS_RST    = 3'h0;
  localparam logic [NUM_EV-1:0] MASK_RST      = 3'h0;
  localparam logic [NUM_IC-1:0] INTERCEPT_RST = 3'h0;
  localparam logic [31:0]       REJECTS_RST   = 32'h0000_0000;

  typedef struct packed {
    logic        valid;
    logic [31:0] instr;
    cac_priv_t   priv;
    logic        debug;
  } cac_req_t;

  typedef struct packed {
    logic      read_only;
    logic      custom;
    cac_priv_t min_priv;
    logic      dbg_m;
    logic      dbg_only;
    logic      counter;
    logic      shadow;
  } cac_cls_t;

  function automatic logic in_range(input logic [11:0] a, input logic [11:0] lo,
                                    input logic [11:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

endpackage

// file: cac_addr_class.sv
// address classifier: access type, level, debug blocks, custom space, counters
`timescale 1ns/100ps
module cac_addr_class (
  // address in
  input  wire logic [11:0]      addr,
  // classification out
  output cac_pkg::cac_cls_t     cls
);

  wire logic               ro;
  wire logic               cust_user;
  wire logic               cust_high;
  wire logic               dbg_m;
  wire logic               dbg_only;
  wire logic               counter;
  wire logic               shadow;
  wire cac_pkg::cac_priv_t min_priv;

  assign ro       = (addr[cac_pkg::ACC_HI:cac_pkg::ACC_LO] == cac_pkg::ACC_RO);
  assign min_priv = cac_pkg::cac_priv_t'(addr[cac_pkg::LVL_HI:cac_pkg::LVL_LO]);
  assign dbg_m    = cac_pkg::in_range(addr, cac_pkg::DBG_M_LO, cac_pkg::DBG_M_HI);
  assign dbg_only = cac_pkg::in_range(addr, cac_pkg::DBG_D_LO, cac_pkg::DBG_D_HI);

  // user space is custom only in its 0x8xx window and read-only top quarter;
  // every other level keeps the top quarter custom in access groups 01, 10 and 11, not in group 00
  assign cust_user = (addr[11:8] == cac_pkg::UCUST_TOP)
                   || (ro && addr[9:8] == 2'h0 && addr[7:6] == cac_pkg::CUST_SUB);
  assign cust_high = (addr[9:8] != 2'h0) && (addr[11:10] != 2'h0)
                   && (addr[7:6] == cac_pkg::CUST_SUB);

  // user read-only counters and their machine-level writable shadows
  assign counter = cac_pkg::in_range(addr, cac_pkg::CNT_LO, cac_pkg::CNT_HI)
                 || cac_pkg::in_range(addr, cac_pkg::CNTH_LO, cac_pkg::CNTH_HI);
  assign shadow  = cac_pkg::in_range(addr, cac_pkg::SHD_LO, cac_pkg::SHD_HI)
                 || cac_pkg::in_range(addr, cac_pkg::SHDH_LO, cac_pkg::SHDH_HI);

  // one driver for the whole struct keeps the output a single continuous assignment
  assign cls = '{read_only: ro, custom: cust_user || cust_high, min_priv: min_priv,
                 dbg_m: dbg_m, dbg_only: dbg_only, counter: counter, shadow: shadow};

endmodule

// file: cac_checker.sv
// register-address access checker: decode, permission check, write merge, status
`timescale 1ns/100ps
module cac_checker #(
  parameter int XLEN = 32
) (
  // clock and control
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  input  wire logic                 ce,
  // decode stage
  input  cac_pkg::cac_req_t         req,
  output logic                      is_csr,
  output logic [11:0]               csr_addr,
  output logic                      trap,
  output logic                      intercept,
  output cac_pkg::cac_cls_t         cls,
  // register storage
  input  wire logic                 present,
  input  wire logic [XLEN-1:0]      old_value,
  input  wire logic [XLEN-1:0]      wr_mask,
  input  wire logic [XLEN-1:0]      src_value,
  output logic                      stg_rd,
  output logic                      stg_wr,
  output logic [XLEN-1:0]           stg_wdata,
  // software register port
  input  wire logic [3:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [31:0]               reg_rdata,
  // interrupt
  output logic                      irq
);

  localparam int NUM_EV_L = cac_pkg::NUM_EV;

  // instruction fields
  wire logic [6:0]           opcode;
  wire logic [2:0]           funct3;
  wire logic [4:0]           rs1;
  wire logic [4:0]           rd;
  wire logic                 wr_intent;
  wire logic                 rd_intent;
  wire cac_pkg::cac_priv_t   eff_priv;
  wire logic                 priv_ok;
  wire logic                 illegal;
  wire logic                 icpt_hit;
  wire logic [XLEN-1:0]      new_value;
  wire logic [NUM_EV_L-1:0]  events;
  wire logic [NUM_EV_L-1:0]  st_clr;
  wire logic [NUM_EV_L-1:0]  next_status;
  wire logic                 sel_status;
  wire logic                 sel_mask;
  wire logic                 sel_icpt;
  wire logic                 sel_rej;
  wire logic [31:0]          next_rdata;

  logic [NUM_EV_L-1:0]           status;
  logic [NUM_EV_L-1:0]           mask;
  logic [cac_pkg::NUM_IC-1:0]    icpt_ctl;
  logic [31:0]                   rejects;

  assign opcode   = req.instr[cac_pkg::OPC_HI:0];
  assign funct3   = req.instr[cac_pkg::F3_HI:cac_pkg::F3_LO];
  assign rs1      = req.instr[cac_pkg::RS1_HI:cac_pkg::RS1_LO];
  assign rd       = req.instr[cac_pkg::RD_HI:cac_pkg::RD_LO];
  assign csr_addr = req.instr[cac_pkg::CSR_HI:cac_pkg::CSR_LO];

  // funct3 000 and 100 are the other system instructions
  assign is_csr = req.valid && (opcode == cac_pkg::OPC_SYSTEM)
                && (funct3[1:0] != 2'h0);
  // swap always writes; set/clear with a zero source only reads
  assign wr_intent = (funct3[1:0] == cac_pkg::F3_SWAP) || (rs1 != 5'h00);
  // a swap into the zero register never reads, so read side effects stay away
  assign rd_intent = !((funct3[1:0] == cac_pkg::F3_SWAP) && (rd == 5'h00));

  cac_addr_class u_class (
    .addr (csr_addr),
    .cls  (cls)
  );

  // debug state counts as machine level
  assign eff_priv = req.debug ? cac_pkg::PRIV_MACH : req.priv;
  // numeric compare: any higher level passes too
  assign priv_ok  = (eff_priv >= cls.min_priv);

  assign illegal = !present
                 || !priv_ok
                 || (wr_intent && cls.read_only)
                 || (cls.dbg_only && !req.debug);

  // interception only ever hits accesses that would otherwise succeed, and it
  // shows to the trapped code as the same illegal-instruction trap
  assign icpt_hit =
      (icpt_ctl[cac_pkg::IC_U_CNT] && req.priv == cac_pkg::PRIV_USER && cls.counter)
   || (icpt_ctl[cac_pkg::IC_S_CNT] && req.priv == cac_pkg::PRIV_SUPER && cls.counter)
   || (icpt_ctl[cac_pkg::IC_CUST] && eff_priv != cac_pkg::PRIV_MACH && cls.custom);
  assign intercept = is_csr && !illegal && icpt_hit;
  assign trap      = is_csr && (illegal || icpt_hit);

  // storage strobes gated by the same-cycle decision
  assign stg_rd = is_csr && rd_intent && !trap;
  assign stg_wr = is_csr && wr_intent && !trap;

  // read-modify-write value; must be combinational to meet the same cycle
  assign new_value = (funct3[1:0] == cac_pkg::F3_SET) ? (old_value | src_value) :
                     (funct3[1:0] == cac_pkg::F3_CLR) ? (old_value & ~src_value) :
                     src_value;
  assign stg_wdata = (old_value & ~wr_mask) | (new_value & wr_mask);

  // events and register port
  assign events[cac_pkg::EV_ILLEGAL]   = is_csr && illegal;
  assign events[cac_pkg::EV_DEBUG]     = is_csr && cls.dbg_only && !req.debug;
  assign events[cac_pkg::EV_INTERCEPT] = intercept;

  assign sel_status = (reg_addr == cac_pkg::REG_STATUS);
  assign sel_mask   = (reg_addr == cac_pkg::REG_MASK);
  assign sel_icpt   = (reg_addr == cac_pkg::REG_INTERCEPT);
  assign sel_rej    = (reg_addr == cac_pkg::REG_REJECTS);

  genvar gi;
  generate
    for (gi = 0; gi < NUM_EV_L; gi++) begin : g_sticky
      assign st_clr[gi]      = reg_wr && sel_status && reg_wdata[gi];
      // a new event beats a clear landing in the same cycle
      assign next_status[gi] = events[gi] || (status[gi] && !st_clr[gi]);
    end
  endgenerate

  assign next_rdata = !reg_rd   ? 32'h0000_0000 :
                      sel_status ? {29'h0000_0000, status} :
                      sel_mask   ? {29'h0000_0000, mask} :
                      sel_icpt   ? {29'h0000_0000, icpt_ctl} :
                      sel_rej    ? rejects :
                      32'h0000_0000;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      status <= cac_pkg::STATUS_RST;
    end else if (ce) begin
      status <= next_status;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mask     <= cac_pkg::MASK_RST;
      icpt_ctl <= cac_pkg::INTERCEPT_RST;
    end else if (ce && reg_wr) begin
      if (sel_mask) begin
        mask <= reg_wdata[NUM_EV_L-1:0];
      end
      if (sel_icpt) begin
        icpt_ctl <= reg_wdata[cac_pkg::NUM_IC-1:0];
      end
    end
  end

  // a write to the reject register clears the count; a reject in the same cycle still counts
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rejects <= cac_pkg::REJECTS_RST;
    end else if (ce) begin
      if (reg_wr && sel_rej) begin
        rejects <= {31'h0000_0000, trap};
      end else if (trap) begin
        rejects <= rejects + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (ce) begin
      reg_rdata <= next_rdata;
    end
  end

  assign irq = |(status & mask);

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  wire logic acc;
  assign acc = is_csr;

  ro_write_trap_a: assert property (
    acc && wr_intent && csr_addr[11:10] == 2'h3 |-> trap && !stg_wr)
    else $error("write to read-only address not trapped");

  low_priv_trap_a: assert property (
    acc && !req.debug && req.priv < csr_addr[9:8] |-> trap && !stg_rd && !stg_wr)
    else $error("under-privileged access not trapped");

  absent_reg_a: assert property (
    acc && !present |-> trap)
    else $error("access to missing register not trapped");

  debug_only_a: assert property (
    acc && !req.debug && csr_addr[11:4] == 8'h7B |-> trap ##1 (!ce || status[1]))
    else $error("debug-only access outside debug state not trapped or logged");

  debug_m_open_a: assert property (
    acc && present && csr_addr[11:4] == 8'h7A && req.priv == cac_pkg::PRIV_MACH
    && icpt_ctl == 3'h0 |-> !trap)
    else $error("machine debug block wrongly refused");

  machine_reach_a: assert property (
    acc && present && req.priv == cac_pkg::PRIV_MACH && !cls.read_only
    && csr_addr[11:4] != 8'h7B && icpt_ctl == 3'h0 |-> !trap && stg_wr == wr_intent)
    else $error("machine level refused a lower-level register");

  ro_bits_kept_a: assert property (
    stg_wr |-> ((stg_wdata ^ old_value) & ~wr_mask) == '0)
    else $error("read-only bits changed by write");

  read_quiet_a: assert property (
    acc && funct3[1:0] != 2'h1 && rs1 == 5'h00 |-> !stg_wr)
    else $error("read-only access raised a write strobe");

  intercept_hidden_a: assert property (
    intercept |-> trap && !stg_rd && !stg_wr)
    else $error("intercepted access not presented as trap");

  reject_count_a: assert property (
    ce && trap && !(reg_wr && sel_rej) |=> rejects == $past(rejects) + 32'h0000_0001)
    else $error("rejected access not counted");

  status_set_wins_a: assert property (
    ce && events[cac_pkg::EV_ILLEGAL] |=> status[cac_pkg::EV_ILLEGAL])
    else $error("illegal event lost against a same-cycle clear");

  rdata_idle_a: assert property (
    ce && !reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data seen outside the answer cycle");

  ce_freeze_a: assert property (
    !ce |=> $stable(status) && $stable(rejects) && $stable(mask))
    else $error("state changed while clock enable low");

  class_shadow_a: assert property (
    cls.shadow |-> !cls.read_only && cls.min_priv == cac_pkg::PRIV_MACH)
    else $error("shadow address not classed machine read/write");

  class_counter_a: assert property (
    cls.counter |-> cls.read_only && cls.min_priv == cac_pkg::PRIV_USER)
    else $error("counter address not classed user read-only");

  idle_quiet_a: assert property (
    !is_csr |-> !trap && !stg_rd && !stg_wr)
    else $error("strobe or trap without a register instruction");

  user_trap_c:   cover property (acc && req.priv == cac_pkg::PRIV_USER && trap);
  dbg_block_c:   cover property (acc && cls.dbg_only && req.debug && !trap);
  legal_write_c: cover property (stg_wr && wr_mask != '1);
  intercept_c:   cover property (intercept);
  irq_c:         cover property (!irq ##1 irq);

endmodule

// file: cac_store_model.sv
// register storage model facing the checker: existence, contents, writable bits
`timescale 1ns/100ps
module cac_store_model (
  // clock
  input  wire logic        clock,
  // access from the checker
  input  wire logic [11:0] addr,
  input  wire logic        stg_wr,
  input  wire logic [31:0] stg_wdata,
  // answer to the checker
  output logic             present,
  output logic [31:0]      old_value,
  output logic [31:0]      wr_mask
);
  logic [31:0] mem [0:15];

  initial begin
    for (int i = 0; i < 16; i++) begin
      mem[i] = {16'hC3C3, 12'h000, 4'(i)};
    end
  end

  // slot F of every group is left unimplemented on purpose
  assign present   = (addr[3:0] != 4'hF);
  assign old_value = mem[addr[3:0]];
  // upper half read-only so partial writes can be seen
  assign wr_mask   = 32'h0000_FFFF;

  always @(posedge clock) begin
    if (stg_wr) begin
      mem[addr[3:0]] <= stg_wdata;
    end
  end
endmodule

// file: tb_cac_checker.sv
// self-checking testbench for the register-address access checker
`timescale 1ns/100ps
module tb_cac_checker;
  logic               clock = 1'b0;
  logic               rst_n = 1'b0;
  logic               ce    = 1'b1;
  cac_pkg::cac_req_t  req   = '0;
  logic [31:0]        src_value = '0;
  logic [3:0]         reg_addr  = '0;
  logic [31:0]        reg_wdata = '0;
  logic               reg_wr = 1'b0;
  logic               reg_rd = 1'b0;
  logic               is_csr, trap, intercept, present, stg_rd, stg_wr, irq;
  logic [11:0]        csr_addr;
  cac_pkg::cac_cls_t  cls, s_cls;
  logic [31:0]        old_value, wr_mask, stg_wdata, reg_rdata, s_wd;
  logic               s_trap, s_int, s_wr, s_rd, s_csr;
  logic [6:0]         opc = 7'h73;
  logic [4:0]         rd_f = 5'h01;
  int                 err_count = 0;
  int                 cmp_count = 0;

  always #25 clock = ~clock;

  cac_checker #(.XLEN(32)) u_dut (
    .clock(clock), .rst_n(rst_n), .ce(ce), .req(req), .is_csr(is_csr),
    .csr_addr(csr_addr), .trap(trap), .intercept(intercept), .cls(cls),
    .present(present), .old_value(old_value), .wr_mask(wr_mask),
    .src_value(src_value), .stg_rd(stg_rd), .stg_wr(stg_wr), .stg_wdata(stg_wdata),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq)
  );

  cac_store_model u_store (
    .clock(clock), .addr(csr_addr), .stg_wr(stg_wr), .stg_wdata(stg_wdata),
    .present(present), .old_value(old_value), .wr_mask(wr_mask)
  );

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      err_count++;
    end
  endtask

  // one instruction held valid for exactly one cycle, outputs captured mid-cycle
  task automatic acc(input logic [1:0] pv, input logic dbg, input logic [2:0] f3,
                     input logic [11:0] a, input logic [4:0] rs, input logic [31:0] src);
    @(posedge clock);
    req       <= '{valid: 1'b1, instr: {a, rs, f3, rd_f, opc},
                   priv: cac_pkg::cac_priv_t'(pv), debug: dbg};
    src_value <= src;
    @(negedge clock);
    {s_trap, s_int, s_wr, s_rd, s_csr, s_wd, s_cls} =
      {trap, intercept, stg_wr, stg_rd, is_csr, stg_wdata, cls};
    @(posedge clock);
    req.valid <= 1'b0;
  endtask

  task automatic rw(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
    @(negedge clock);
  endtask

  task automatic rr(input logic [3:0] a, input logic [31:0] exp, input string name);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    @(negedge clock);
    chk(name, exp, reg_rdata);
  endtask

  task automatic t_priv();
    logic [11:0] ad [7] = '{12'h300, 12'h300, 12'h100, 12'h100, 12'h100, 12'h200, 12'h200};
    logic [1:0]  pv [7] = '{2'h0, 2'h3, 2'h1, 2'h0, 2'h3, 2'h2, 2'h1};
    logic        ex [7] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
    for (int i = 0; i < 7; i++) begin
      acc(pv[i], 1'b0, 3'h2, ad[i], 5'h00, 32'h0);
      chk("level trap", 32'(ex[i]), 32'(s_trap));
      chk("level read", 32'(!ex[i]), 32'(s_rd));
    end
  endtask

  task automatic t_ro();
    acc(2'h3, 1'b0, 3'h1, 12'hC00, 5'h01, 32'h1);
    chk("ro write trap", 32'h1, 32'(s_trap));
    chk("ro write strobe", 32'h0, 32'(s_wr));
    acc(2'h0, 1'b0, 3'h2, 12'hC00, 5'h00, 32'h1);
    chk("ro read trap", 32'h0, 32'(s_trap));
    chk("read no write", 32'h0, 32'(s_wr));
    acc(2'h3, 1'b0, 3'h1, 12'hB00, 5'h01, 32'h1);
    chk("shadow write", 32'h1, 32'({s_trap, s_wr, s_cls.shadow} == 3'b011));
    acc(2'h3, 1'b0, 3'h2, 12'h30F, 5'h00, 32'h0);
    chk("absent trap", 32'h1, 32'(s_trap));
  endtask

  task automatic t_dbg();
    acc(2'h3, 1'b0, 3'h2, 12'h7B0, 5'h00, 32'h0);
    chk("dbg only no dbg", 32'h1, 32'(s_trap));
    acc(2'h3, 1'b1, 3'h2, 12'h7B0, 5'h00, 32'h0);
    chk("dbg only in dbg", 32'h0, 32'(s_trap));
    acc(2'h3, 1'b0, 3'h2, 12'h7A0, 5'h00, 32'h0);
    chk("dbg machine", 32'h0, 32'(s_trap));
  endtask

  task automatic t_merge();
    acc(2'h3, 1'b0, 3'h1, 12'h341, 5'h01, 32'hFFFF_AAAA);
    chk("swap data", 32'hC3C3_AAAA, s_wd);
    chk("swap strobe", 32'h1, 32'({s_trap, s_wr} == 2'b01));
    acc(2'h3, 1'b0, 3'h2, 12'h341, 5'h01, 32'h0000_0055);
    chk("set data", 32'hC3C3_AAFF, s_wd);
    acc(2'h3, 1'b0, 3'h3, 12'h341, 5'h01, 32'hFFFF_000F);
    chk("clear data", 32'hC3C3_AAF0, s_wd);
    rd_f = 5'h00;
    acc(2'h3, 1'b0, 3'h5, 12'h342, 5'h03, 32'h0000_0003);
    rd_f = 5'h01;
    chk("imm swap strobes", 32'h1, 32'({s_wr, s_rd} == 2'b10));
    chk("imm swap data", 32'hC3C3_0003, s_wd);
  endtask

  // with the enable low a trap still answers but nothing is counted
  task automatic t_ce();
    rw(4'hC, 32'h0);
    @(posedge clock);
    ce <= 1'b0;
    acc(2'h0, 1'b0, 3'h2, 12'h300, 5'h00, 32'h0);
    chk("frozen trap", 32'h1, 32'(s_trap));
    @(posedge clock);
    ce <= 1'b1;
    rr(4'hC, 32'h0, "frozen rejects");
  endtask

  task automatic t_cls();
    logic [11:0] ad [6] = '{12'h800, 12'hCC0, 12'h7C0, 12'h300, 12'hC00, 12'hA12};
    logic [3:0]  ex [6] = '{4'h4, 4'hC, 4'h7, 4'h3, 4'h8, 4'h2};
    for (int i = 0; i < 6; i++) begin
      acc(2'h3, 1'b0, 3'h2, ad[i], 5'h00, 32'h0);
      chk("class", 32'(ex[i]), 32'({s_cls.read_only, s_cls.custom, s_cls.min_priv}));
    end
    chk("address field", 32'h0A12, 32'(csr_addr));
    opc = 7'h33;
    acc(2'h3, 1'b0, 3'h2, 12'h300, 5'h00, 32'h0);
    chk("not system", 32'h0, 32'(s_csr));
    opc = 7'h73;
  endtask

  task automatic t_irq();
    rw(4'hC, 32'h0);
    rw(4'h0, 32'h7);
    acc(2'h0, 1'b0, 3'h2, 12'h300, 5'h00, 32'h0);
    acc(2'h3, 1'b0, 3'h1, 12'hC00, 5'h01, 32'h0);
    rr(4'h0, 32'h1, "status");
    rr(4'hC, 32'h2, "rejects");
    chk("irq masked", 32'h0, 32'(irq));
    rw(4'h4, 32'h1);
    chk("irq set", 32'h1, 32'(irq));
    rw(4'h0, 32'h1);
    chk("irq cleared", 32'h0, 32'(irq));
    rr(4'h4, 32'h1, "mask");
    rr(4'h2, 32'h0, "unmapped");
  endtask

  task automatic t_icpt();
    rw(4'h8, 32'h1);
    rw(4'h0, 32'h7);
    acc(2'h0, 1'b0, 3'h2, 12'hC00, 5'h00, 32'h0);
    chk("icpt hit", 32'h3, 32'({s_trap, s_int}));
    rr(4'h0, 32'h4, "icpt status");
    acc(2'h3, 1'b0, 3'h2, 12'hC00, 5'h00, 32'h0);
    chk("icpt machine", 32'h0, 32'({s_trap, s_int}));
    rw(4'h8, 32'h6);
    acc(2'h1, 1'b0, 3'h2, 12'hC80, 5'h00, 32'h0);
    chk("icpt super cnt", 32'h3, 32'({s_trap, s_int}));
    acc(2'h1, 1'b0, 3'h2, 12'h5C0, 5'h00, 32'h0);
    chk("icpt custom", 32'h3, 32'({s_trap, s_int}));
    acc(2'h3, 1'b1, 3'h2, 12'h7C0, 5'h00, 32'h0);
    chk("icpt debug custom", 32'h0, 32'({s_trap, s_int}));
    rw(4'h8, 32'h0);
    acc(2'h0, 1'b0, 3'h2, 12'hC00, 5'h00, 32'h0);
    chk("icpt off", 32'h0, 32'({s_trap, s_int}));
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clock);
    err_count++;
    test_done();
  end

  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rr(4'(i * 4), 32'h0, "reset value");
    end
    t_priv();
    t_ro();
    t_dbg();
    t_merge();
    t_cls();
    t_irq();
    t_icpt();
    t_ce();
    test_done();
  end
endmodule
